// ---- testbench/pcm_bus_asserts.sv ----
// Protocol checker watching the card bus between host and card ends
`timescale 1ns/10ps
`default_nettype none
module pcm_bus_asserts (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [pcm_pkg::ADDR_W-1:0] addr,
  input wire logic [1:0] ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reg_n,
  input wire logic wait_n,
  input wire logic host_d_oe,
  input wire logic card_d_oe
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////
  AST_ONE_DRIVER: assert property (!(card_d_oe && host_d_oe))
    else $error("data lines driven by both ends");
  AST_READ_DRIVE: assert property ($rose(card_d_oe) |-> !oe_n && ce_n != 2'h3)
    else $error("card drives data outside an enabled read");
  // Release lags the strobes by the card's synchroniser
  AST_DRIVE_RELEASE: assert property (card_d_oe && (oe_n || ce_n == 2'h3) |-> ##[1:5] !card_d_oe)
    else $error("card kept driving data after the read ended");
  AST_WAIT_HOLDS: assert property (!wait_n |=> $stable(ce_n) && $stable(oe_n) && $stable(we_n))
    else $error("strobes changed while wait was low");
  AST_WAIT_IN_CYCLE: assert property (!wait_n |-> ce_n != 2'h3 && (!oe_n || !we_n))
    else $error("wait low outside a bus cycle");
  AST_RW_EXCL: assert property (!(!oe_n && !we_n))
    else $error("read and write strobes low together");
  AST_REG_HIGH: assert property (ce_n != 2'h3 |-> reg_n)
    else $error("attribute select low in a memory cycle");
  AST_ADDR_STABLE: assert property (ce_n != 2'h3 && $past(ce_n) != 2'h3 |-> $stable(addr))
    else $error("address moved inside a cycle");
  AST_RECOVER: assert property ($rose(ce_n == 2'h3) |-> (ce_n == 2'h3)[*5])
    else $error("enables released too briefly between cycles");
  AST_WAIT_ANSWER: assert property ($rose(ce_n != 2'h3) |-> ##[2:8] !wait_n)
    else $error("card did not answer a cycle with wait");
  ////////////////////////////////////////////////////////////////
  CV_WORD_READ: cover property (ce_n == 2'h0 && !oe_n && card_d_oe);
  CV_LOW_WRITE: cover property (ce_n == 2'h2 && !we_n);
  CV_HIGH_READ: cover property (ce_n == 2'h1 && !oe_n && card_d_oe);
  CV_LONG_WAIT: cover property (!wait_n [*2]);
endmodule
`default_nettype wire

// ---- testbench/tb_pc_card_memory_cycle_port.sv ----
// Self-checking bench joining host end and card end over the card bus
`timescale 1ns/10ps
`default_nettype none
module tb_pc_card_memory_cycle_port;
  logic clock_i, rstn_i, req_i, wr_i, card_reset_i, refresh_req_i;
  logic busy_o, done_o, refresh_valid_o, card_ready_o;
  logic [pcm_pkg::ADDR_W-1:0] addr_i;
  logic [1:0] ben_i;
  logic [15:0] wdata_i, rdata_o, refresh_data_o, access_count_o;
  logic [7:0] refresh_addr_i;
  int err_total, check_count, cyc, wait_lo;
  pcm_bus_if u_pcm_bus_if ();
  pcm_host u_pcm_host (.clock_i(clock_i), .rstn_i(rstn_i), .bus(u_pcm_bus_if), .req_i(req_i),
    .wr_i(wr_i), .addr_i(addr_i), .ben_i(ben_i), .wdata_i(wdata_i), .card_reset_i(card_reset_i),
    .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
  pcm_card u_pcm_card (.clock_i(clock_i), .rstn_i(rstn_i), .bus(u_pcm_bus_if),
    .refresh_req_i(refresh_req_i), .refresh_addr_i(refresh_addr_i),
    .refresh_data_o(refresh_data_o), .refresh_valid_o(refresh_valid_o),
    .card_ready_o(card_ready_o), .access_count_o(access_count_o));
  pcm_bus_asserts u_pcm_bus_asserts (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr(u_pcm_bus_if.addr), .ce_n(u_pcm_bus_if.ce_n), .oe_n(u_pcm_bus_if.oe_n),
    .we_n(u_pcm_bus_if.we_n), .reg_n(u_pcm_bus_if.reg_n), .wait_n(u_pcm_bus_if.wait_n),
    .host_d_oe(u_pcm_bus_if.host_d_oe), .card_d_oe(u_pcm_bus_if.card_d_oe));
  ////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'h0;
    forever #50 clock_i = ~clock_i;
  end
  // Ceiling far above the few hundred cycles the scenarios need
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (!u_pcm_bus_if.wait_n) wait_lo <= wait_lo + 1;
    if (cyc == 8000) begin
      err_total = err_total + 1;
      conclude();
    end
  end
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One complete host cycle; req dropped at the edge that takes it
  task automatic host_op(input logic wr, input logic [25:0] a, input logic [1:0] be,
      input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    req_i <= 1'h1;
    wr_i <= wr;
    addr_i <= a;
    ben_i <= be;
    wdata_i <= wd;
    @(posedge clock_i);
    req_i <= 1'h0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (done_o !== 1'h1 && n < 400);
    chk("done seen", {15'h0000, done_o}, 16'h0001);
    while (busy_o !== 1'h0 && n < 800) begin
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_word();
    host_op(1'h1, 26'h2000010, 2'h3, 16'hA5C3);
    host_op(1'h0, 26'h0000010, 2'h3, 16'h0000);
    chk("word alias", rdata_o, 16'hA5C3);
    host_op(1'h0, 26'h0000010, 2'h0, 16'h0000);
    chk("word both enables", rdata_o, 16'hA5C3);
  endtask
  task automatic t_bytes();
    host_op(1'h1, 26'h0000020, 2'h3, 16'h1234);
    host_op(1'h1, 26'h0000020, 2'h1, 16'h0099);
    host_op(1'h0, 26'h0000020, 2'h3, 16'h0000);
    chk("even byte write", rdata_o, 16'h1299);
    host_op(1'h1, 26'h0000021, 2'h1, 16'h0077);
    host_op(1'h0, 26'h0000020, 2'h3, 16'h0000);
    chk("odd byte low lane", rdata_o, 16'h7799);
    host_op(1'h1, 26'h0000021, 2'h2, 16'hEE00);
    host_op(1'h0, 26'h0000020, 2'h3, 16'h0000);
    chk("high lane write", rdata_o, 16'hEE99);
    host_op(1'h0, 26'h0000021, 2'h1, 16'h0000);
    chk("odd read low lane", {8'h00, rdata_o[7:0]}, 16'h00EE);
    host_op(1'h0, 26'h0000021, 2'h2, 16'h0000);
    chk("odd read high lane", {rdata_o[15:8], 8'h00}, 16'hEE00);
  endtask
  task automatic t_refresh();
    int n, plain, busy_w;
    n = 0;
    plain = wait_lo;
    host_op(1'h0, 26'h0000010, 2'h3, 16'h0000);
    plain = wait_lo - plain;
    @(posedge clock_i);
    refresh_addr_i <= 8'h08;
    refresh_req_i <= 1'h1;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (refresh_valid_o !== 1'h1 && n < 50);
    chk("refresh data", refresh_data_o, 16'hA5C3);
    // A held request is blocked by served_reg until after the host cycle; re-raise it in arbitration
    @(posedge clock_i);
    refresh_req_i <= 1'h0;
    busy_w = wait_lo;
    fork
      host_op(1'h0, 26'h0000010, 2'h3, 16'h0000);
      begin
        @(negedge u_pcm_bus_if.wait_n);
        refresh_req_i <= 1'h1;
      end
    join
    busy_w = wait_lo - busy_w;
    chk("read beside refresh", rdata_o, 16'hA5C3);
    chk("wait stretched", {15'h0000, busy_w > plain}, 16'h0001);
    @(posedge clock_i);
    refresh_req_i <= 1'h0;
  endtask
  task automatic t_card_reset();
    logic [15:0] c;
    c = access_count_o;
    host_op(1'h0, 26'h0000010, 2'h3, 16'h0000);
    chk("access counted", access_count_o, c + 16'h0001);
    @(posedge clock_i);
    card_reset_i <= 1'h1;
    repeat (6) @(posedge clock_i);
    #1;
    chk("ready in card reset", {15'h0000, card_ready_o}, 16'h0000);
    chk("count cleared", access_count_o, 16'h0000);
    @(posedge clock_i);
    card_reset_i <= 1'h0;
    repeat (6) @(posedge clock_i);
    #1;
    chk("ready after card reset", {15'h0000, card_ready_o}, 16'h0001);
    host_op(1'h0, 26'h0000010, 2'h3, 16'h0000);
    chk("memory kept", rdata_o, 16'hA5C3);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {err_total, check_count, cyc, wait_lo} = '0;
    {rstn_i, req_i, wr_i, card_reset_i, refresh_req_i} = '0;
    {addr_i, ben_i, wdata_i, refresh_addr_i} = '0;
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'h1;
    repeat (6) @(posedge clock_i);
    #1;
    chk("ready after reset", {15'h0000, card_ready_o}, 16'h0001);
    chk("count after reset", access_count_o, 16'h0000);
    t_word();
    t_bytes();
    t_refresh();
    t_card_reset();
    conclude();
  end
endmodule
`default_nettype wire

// ---- verilog/pcm_bus_if.sv ----
// Card bus wires joining the host socket end and the card end
`timescale 1ns/10ps
`default_nettype none
interface pcm_bus_if;
  logic [pcm_pkg::ADDR_W-1:0] addr;
  logic [1:0] ce_n;
  logic oe_n;
  logic we_n;
  logic reg_n;
  logic card_reset;
  logic wait_n;
  logic [pcm_pkg::DATA_W-1:0] host_d;
  logic host_d_oe;
  logic [pcm_pkg::DATA_W-1:0] card_d;
  logic card_d_oe;
  logic [pcm_pkg::DATA_W-1:0] data;

  // Resolved data lines; nobody driving reads as all ones (pull-ups)
  assign data = card_d_oe ? card_d : (host_d_oe ? host_d : 16'hFFFF);

  modport host (
    output addr, ce_n, oe_n, we_n, reg_n, card_reset, host_d, host_d_oe,
    input wait_n, data
  );
  modport card (
    input addr, ce_n, oe_n, we_n, reg_n, card_reset, data,
    output wait_n, card_d, card_d_oe
  );
endinterface
`default_nettype wire

// ---- verilog/pcm_card.sv ----
// Card end: common-memory cycle decode, wait stretching and refresh arbitration
//
// How it works
// - Host opens cycle with enables, ends releasing them
// - Wait low stretches cycle; host holds strobes
// - Common memory needs attribute select high
// - Low enable only: byte on D[7:0], A0 picks
// - Both enables: sixteen-bit word transfer
// - High enable only: odd byte on D[15:8]
// - Output enable low requests a read
// - Write enable low, output enable high writes
// - Twenty-six address bits span 64M spaces
// - Highest numbered line is most significant
// - Card reset clears configuration state
// - All bus strobes synchronised before use
// - Wait held while refresh owns the buffer
// - Bus logic runs on a local clock
`timescale 1ns/10ps
`default_nettype none
module pcm_card (
  input wire logic clock_i,
  input wire logic rstn_i,
  pcm_bus_if.card bus,
  input wire logic refresh_req_i,
  input wire logic [pcm_pkg::MEM_AW-1:0] refresh_addr_i,
  output logic [pcm_pkg::DATA_W-1:0] refresh_data_o,
  output logic refresh_valid_o,
  output logic card_ready_o,
  output logic [15:0] access_count_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARB,
    ST_DONE
  } pcm_card_state_e;

  // Lane mask from enables and A0: bit 1 high byte, bit 0 low byte
  function automatic logic [1:0] pcm_lanes(input logic [1:0] ce_n, input logic a0);
    logic [1:0] m;
    m = 2'h0;
    unique case (ce_n)
      pcm_pkg::CE_WORD: m = 2'h3;
      pcm_pkg::CE_LOW: m = a0 ? 2'h2 : 2'h1;
      pcm_pkg::CE_HIGH: m = 2'h2;
      pcm_pkg::CE_NONE: m = 2'h0;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; stage one feeds stage two only
  logic [4:0] strb_s1_reg;
  logic [4:0] strb_s2_reg;
  logic [pcm_pkg::ADDR_W-1:0] addr_s1_reg;
  logic [pcm_pkg::ADDR_W-1:0] addr_s2_reg;
  logic [pcm_pkg::DATA_W-1:0] data_s1_reg;
  logic [pcm_pkg::DATA_W-1:0] data_s2_reg;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strb_s1_reg <= 5'h1F;
      strb_s2_reg <= 5'h1F;
    end else begin
      strb_s1_reg <= {bus.ce_n, bus.oe_n, bus.we_n, bus.reg_n};
      strb_s2_reg <= strb_s1_reg;
    end
  end

  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= bus.card_reset;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_s1_reg <= 26'h0;
      addr_s2_reg <= 26'h0;
      data_s1_reg <= 16'h0;
      data_s2_reg <= 16'h0;
    end else begin
      addr_s1_reg <= bus.addr;
      addr_s2_reg <= addr_s1_reg;
      data_s1_reg <= bus.data;
      data_s2_reg <= data_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the synchronised strobes
  wire logic [1:0] ce_n_s = strb_s2_reg[4:3];
  wire logic oe_n_s = strb_s2_reg[2];
  wire logic we_n_s = strb_s2_reg[1];
  wire logic reg_n_s = strb_s2_reg[0];
  wire logic card_rst_s = rst_s2_reg;
  wire logic ce_any = (ce_n_s != pcm_pkg::CE_NONE);
  wire logic is_read = !oe_n_s;
  wire logic is_write = oe_n_s && !we_n_s;
  // Attribute cycles are left to other logic; this port stays silent
  wire logic common_hit = ce_any && reg_n_s && (is_read || is_write);
  wire logic [1:0] lanes = pcm_lanes(ce_n_s, addr_s2_reg[0]);
  // Only A[MEM_AW:1] index the buffer; upper bits alias (A25 is the MSB)
  wire logic [pcm_pkg::MEM_AW-1:0] word_idx = addr_s2_reg[pcm_pkg::MEM_AW:1];

  ////////////////////////////////////////////////////////////////////////////
  // Buffer shared by the host port and display refresh
  logic [pcm_pkg::DATA_W-1:0] mem [0:pcm_pkg::MEM_WORDS-1];
  wire logic [pcm_pkg::DATA_W-1:0] mem_word = mem[word_idx];

  pcm_card_state_e state_reg;
  pcm_card_state_e state_next;
  logic served_reg;
  logic read_cyc_reg;
  logic wait_n_reg;
  logic [pcm_pkg::DATA_W-1:0] d_reg;
  logic d_oe_reg;
  logic refresh_valid_reg;
  logic [pcm_pkg::DATA_W-1:0] refresh_data_reg;
  logic card_ready_reg;
  logic [15:0] access_count_reg;

  // Refresh first, but one host access follows each refresh word
  wire logic refresh_grant = refresh_req_i && !served_reg && state_reg != ST_DONE;
  wire logic host_grant = (state_reg == ST_ARB) && !refresh_grant && common_hit;
  wire logic cyc_gone = !ce_any;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (common_hit && !card_rst_s) state_next = ST_ARB;
      end
      ST_ARB: begin
        if (cyc_gone) state_next = ST_IDLE;
        else if (host_grant) state_next = ST_DONE;
      end
      ST_DONE: begin
        if (cyc_gone) state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Wait low from cycle detect until data is ready or taken
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_n_reg <= 1'b1;
    end else begin
      wait_n_reg <= (state_next != ST_ARB);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      served_reg <= 1'b0;
    end else if (refresh_grant) begin
      served_reg <= 1'b1;
    end else if (host_grant || !refresh_req_i) begin
      served_reg <= 1'b0;
    end
  end

  // Read lane steering; the odd byte moves to D[7:0] for low-enable reads
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      d_reg <= 16'h0;
      read_cyc_reg <= 1'b0;
    end else if (host_grant) begin
      read_cyc_reg <= is_read;
      if (ce_n_s == pcm_pkg::CE_LOW) begin
        d_reg <= {8'h0, lanes[1] ? mem_word[15:8] : mem_word[7:0]};
      end else begin
        d_reg <= mem_word;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (host_grant && is_write) begin
      if (ce_n_s == pcm_pkg::CE_LOW) begin
        if (lanes[0]) mem[word_idx][7:0] <= data_s2_reg[7:0];
        if (lanes[1]) mem[word_idx][15:8] <= data_s2_reg[7:0];
      end else begin
        if (lanes[0]) mem[word_idx][7:0] <= data_s2_reg[7:0];
        if (lanes[1]) mem[word_idx][15:8] <= data_s2_reg[15:8];
      end
    end
  end

  // Data lines released once the synchronised enable or output enable goes away
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      d_oe_reg <= 1'b0;
    end else begin
      d_oe_reg <= (state_next == ST_DONE) && (read_cyc_reg || host_grant && is_read)
        && ce_any && !oe_n_s;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      refresh_valid_reg <= 1'b0;
      refresh_data_reg <= 16'h0;
    end else begin
      refresh_valid_reg <= refresh_grant;
      if (refresh_grant) refresh_data_reg <= mem[refresh_addr_i];
    end
  end

  // Configuration state: cleared by the bus reset line
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      card_ready_reg <= 1'b0;
      access_count_reg <= 16'h0;
    end else if (card_rst_s) begin
      card_ready_reg <= 1'b0;
      access_count_reg <= 16'h0;
    end else begin
      card_ready_reg <= 1'b1;
      if (host_grant) access_count_reg <= access_count_reg + 16'h1;
    end
  end

  assign bus.wait_n = wait_n_reg;
  assign bus.card_d = d_reg;
  assign bus.card_d_oe = d_oe_reg;
  assign refresh_data_o = refresh_data_reg;
  assign refresh_valid_o = refresh_valid_reg;
  assign card_ready_o = card_ready_reg;
  assign access_count_o = access_count_reg;

endmodule
`default_nettype wire

// ---- verilog/pcm_host.sv ----
// Host socket end: runs common-memory cycles from a simple request port
`timescale 1ns/10ps
`default_nettype none
module pcm_host (
  input wire logic clock_i,
  input wire logic rstn_i,
  pcm_bus_if.host bus,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [pcm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [1:0] ben_i,
  input wire logic [pcm_pkg::DATA_W-1:0] wdata_i,
  input wire logic card_reset_i,
  output logic busy_o,
  output logic done_o,
  output logic [pcm_pkg::DATA_W-1:0] rdata_o
);

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_SETTLE,
    HS_WAIT,
    HS_RECOVER
  } pcm_host_state_e;

  // Wait and data come from the card's clock; resync before use
  logic [1:0] wait_sync_reg;
  logic [pcm_pkg::DATA_W-1:0] data_s1_reg;
  logic [pcm_pkg::DATA_W-1:0] data_s2_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_sync_reg <= 2'h3;
      data_s1_reg <= 16'h0;
      data_s2_reg <= 16'h0;
    end else begin
      wait_sync_reg <= {wait_sync_reg[0], bus.wait_n};
      data_s1_reg <= bus.data;
      data_s2_reg <= data_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pcm_host_state_e state_reg;
  logic [3:0] cnt_reg;
  logic wr_reg;
  logic [1:0] ben_reg;
  logic [pcm_pkg::ADDR_W-1:0] addr_reg;
  logic [pcm_pkg::DATA_W-1:0] wdata_reg;
  logic [pcm_pkg::DATA_W-1:0] rdata_reg;
  logic done_reg;
  logic reset_reg;
  logic busy_reg;

  wire logic strobing = (state_reg == HS_SETTLE) || (state_reg == HS_WAIT);
  wire logic [1:0] ce_sel = (ben_reg == pcm_pkg::BEN_WORD) ? pcm_pkg::CE_WORD :
    (ben_reg == pcm_pkg::BEN_HIGH) ? pcm_pkg::CE_HIGH : pcm_pkg::CE_LOW;
  wire logic wait_done = wait_sync_reg[1] && (state_reg == HS_WAIT);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= HS_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      ben_reg <= pcm_pkg::BEN_WORD;
      addr_reg <= 26'h0;
      wdata_reg <= 16'h0;
      rdata_reg <= 16'h0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        HS_IDLE: begin
          if (req_i && !reset_reg) begin
            wr_reg <= wr_i;
            ben_reg <= (ben_i == 2'h0) ? pcm_pkg::BEN_WORD : ben_i;
            addr_reg <= addr_i;
            wdata_reg <= wdata_i;
            busy_reg <= 1'b1;
            state_reg <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          // Address settles a cycle before any enable falls
          cnt_reg <= pcm_pkg::SETTLE_CNT;
          state_reg <= HS_SETTLE;
        end
        HS_SETTLE: begin
          // Card cannot show wait sooner than its sync delay
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) state_reg <= HS_WAIT;
        end
        HS_WAIT: begin
          if (wait_done) begin
            if (!wr_reg) rdata_reg <= data_s2_reg;
            cnt_reg <= pcm_pkg::RECOVER_CNT;
            done_reg <= 1'b1;
            state_reg <= HS_RECOVER;
          end
        end
        HS_RECOVER: begin
          // Enables stay high long enough for the card to see the end
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            state_reg <= HS_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered bus drive
  logic [1:0] ce_n_reg;
  logic oe_n_reg;
  logic we_n_reg;
  logic d_oe_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ce_n_reg <= pcm_pkg::CE_NONE;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      d_oe_reg <= 1'b0;
      reset_reg <= 1'b0;
    end else begin
      ce_n_reg <= (strobing && !wait_done) || state_reg == HS_SETUP ?
        ce_sel : pcm_pkg::CE_NONE;
      oe_n_reg <= !((strobing && !wait_done || state_reg == HS_SETUP) && !wr_reg);
      we_n_reg <= !((strobing && !wait_done || state_reg == HS_SETUP) && wr_reg);
      d_oe_reg <= (strobing && !wait_done || state_reg == HS_SETUP) && wr_reg;
      reset_reg <= card_reset_i;
    end
  end

  // Low-enable byte writes carry the byte on D[7:0]; high-only on D[15:8]
  assign bus.host_d = (ben_reg == pcm_pkg::BEN_LOW) ? {8'h0, wdata_reg[7:0]} : wdata_reg;
  assign bus.host_d_oe = d_oe_reg;
  assign bus.addr = addr_reg;
  assign bus.ce_n = ce_n_reg;
  assign bus.oe_n = oe_n_reg;
  assign bus.we_n = we_n_reg;
  assign bus.reg_n = 1'b1;
  assign bus.card_reset = reset_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign rdata_o = rdata_reg;

endmodule
`default_nettype wire

// ---- verilog/pcm_pkg.sv ----
// Shared widths, lane codes and timing counts for the card memory port
package pcm_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int MEM_AW = 8;
  localparam int MEM_WORDS = 256;
  localparam int CLK_PERIOD_NS = 100;
  // Card answer latency: two sync stages, decode, wait register
  localparam int SETTLE_NS = 600;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_NS = 600;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_CNT = SETTLE_CYC[3:0];
  localparam logic [3:0] RECOVER_CNT = RECOVER_CYC[3:0];
  localparam logic [1:0] CE_NONE = 2'h3;
  localparam logic [1:0] CE_LOW = 2'h2;
  localparam logic [1:0] CE_HIGH = 2'h1;
  localparam logic [1:0] CE_WORD = 2'h0;
  localparam logic [1:0] BEN_LOW = 2'h1;
  localparam logic [1:0] BEN_HIGH = 2'h2;
  localparam logic [1:0] BEN_WORD = 2'h3;
endpackage
